// ==== core/cpm_pkg.sv ====
// Constants, register map and state types for the clock and power-mode
// control block.
// Assumes a single 125 MHz APB clock and asynchronous pins, synchronised inside the block.
package cpm_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_FREQ_10KHZ = 100000 / CLK_PERIOD_NS;
  localparam int REF_FREQ_10KHZ = 1356;
  localparam real STARTUP_TIME_MS = 2.5;
  localparam int STARTUP_CYCLES_DEF =
    int'($floor(STARTUP_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int STANDBY_EXIT_TIME_US = 15;
  localparam int STANDBY_EXIT_CYCLES =
    (STANDBY_EXIT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int SU_W = 20;
  localparam int ACC_W = 23;

  // ************************************************************
  // Register offsets and fields
  // ************************************************************
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PLL = 8'h08;
  localparam logic [7:0] ADDR_WAKE = 8'h0c;
  localparam logic [7:0] ADDR_TRIM = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam int CMD_STBY_BIT = 7;
  localparam int CTRL_RADIO_OFF_BIT = 0;
  localparam int CTRL_CLK_EN_BIT = 1;
  localparam int PLL_OUT_LSB = 8;
  localparam int WAKE_EN_BIT = 16;
  localparam int TRIM_START_BIT = 8;
  localparam int TRIM_BUSY_BIT = 9;
  localparam int STAT_CNT_LSB = 16;

  // ************************************************************
  // Values and reset values
  // ************************************************************
  localparam logic [4:0] CMD_IDLE = 5'h00;
  localparam logic [7:0] FB_RATIO_A = 8'h17;
  localparam logic [7:0] FB_RATIO_B = 8'h1b;
  localparam logic [7:0] FB_RATIO_C = 8'h1c;
  localparam logic [7:0] OUT_DIV_MIN = 8'h10;
  localparam logic [7:0] OUT_DIV_RESET = 8'h4e;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [15:0] WAKE_RELOAD_RESET = 16'h0010;
  localparam logic [9:0] REF_RELOAD = 10'h3ff;
  localparam logic [9:0] TRIM_LOW = 10'h0ae;
  localparam logic [9:0] TRIM_HIGH = 10'h0b0;

  typedef enum logic [2:0] {
    T_IDLE, T_ARM, T_EDGE, T_COUNT, T_APPLY
  } cpm_trim_e;

endpackage

// ==== core/cpm_clkdiv.sv ====
// Fractional divider that models the PLL output clock on the pin.
// Assumes legal divider settings; the register file screens them.
module cpm_clkdiv
  import cpm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic clear,
  input wire logic [7:0] fb_div,
  input wire logic [7:0] out_div,
  // Clock level
  output logic level
);

  logic [ACC_W-1:0] acc_r, acc_nxt;
  logic level_r, level_nxt;
  logic [ACC_W-1:0] step;
  logic [ACC_W-1:0] limit;
  logic [ACC_W:0] sum;

  // Two phase steps per output period at 13.56 MHz * fb / out
  assign step = ACC_W'(fb_div) * ACC_W'(2 * REF_FREQ_10KHZ);
  assign limit = ACC_W'(out_div) * ACC_W'(CLK_FREQ_10KHZ);
  assign sum = {1'b0, acc_r} + {1'b0, step};

  // Phase accumulator
  always_comb begin
    acc_nxt = acc_r;
    level_nxt = level_r;
    if (clear) begin
      acc_nxt = '0;
      level_nxt = 1'b0;
    end else if (run) begin
      if (sum >= {1'b0, limit}) begin
        acc_nxt = ACC_W'(sum - {1'b0, limit});
        level_nxt = ~level_r;
      end else begin
        acc_nxt = sum[ACC_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
      level_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;

endmodule // cpm_clkdiv

// ==== core/cpm_top.sv ====
// Clock output, slow oscillator auto-trim and power-mode control.
// Assumes an APB master on pclk and asynchronous pins from the board.
//
// Local design decisions: register access over APB and the register addresses.
module cpm_top
  import cpm_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Board pins
  input wire logic shutdown_pin,
  input wire logic slow_osc_in,
  input wire logic xtal_ref_in,
  // Clock output pin
  output logic clock_output_pin,
  output logic clock_output_pin_oe,
  // Status and analog controls
  output logic radio_tx_on,
  output logic radio_rx_on,
  output logic [7:0] slow_osc_trim,
  output logic standby_active,
  output logic device_ready
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] meta_r, sync_r, prev_r;
  logic sd, lfo_rise, ref_rise;

  // Two flops per pin, third stage for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      prev_r <= 3'h0;
    end else begin
      meta_r <= {xtal_ref_in, slow_osc_in, shutdown_pin};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign sd = sync_r[0];
  assign lfo_rise = sync_r[1] & ~prev_r[1];
  assign ref_rise = sync_r[2] & ~prev_r[2];

  // ************************************************************
  // APB access
  // ************************************************************
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic acc, fire, wr_ok, refuse;
  logic sw_trim_wr, trim_start, abort, stby_exit;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == ADDR_CMD || a == ADDR_CTRL || a == ADDR_PLL ||
           a == ADDR_WAKE || a == ADDR_TRIM || a == ADDR_STAT;
  endfunction

  // Control registers
  logic [4:0] cmd_code_r, cmd_code_nxt;
  logic standby_r, standby_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [7:0] fb_r, fb_nxt, out_r, out_nxt;
  logic [15:0] wk_reload_r, wk_reload_nxt;
  logic wk_en_r, wk_en_nxt;
  logic [SU_W-1:0] su_cnt_r, su_cnt_nxt;
  logic ready_r, ready_nxt;
  // Trim state
  cpm_trim_e trim_st_r, trim_st_nxt;
  logic [7:0] trim_r, trim_nxt;
  logic [9:0] ref_cnt_r, ref_cnt_nxt, last_cnt_r, last_cnt_nxt;
  logic [15:0] wk_cnt_r, wk_cnt_nxt;
  logic wake_evt;

  assign acc = psel & penable;
  assign fire = acc & pready_r;
  // Writes other than the command register are refused in standby
  // standby retention
  assign refuse = ~is_mapped(paddr) | sd |
                  (pwrite & standby_r & (paddr != ADDR_CMD));
  assign wr_ok = fire & pwrite & ~refuse;
  assign sw_trim_wr = wr_ok & (paddr == ADDR_TRIM) & (trim_st_r == T_IDLE);
  assign trim_start = sw_trim_wr & pwdata[TRIM_START_BIT];
  assign abort = wr_ok & (paddr == ADDR_CMD) & (pwdata[4:0] == CMD_IDLE);
  assign stby_exit = wr_ok & (paddr == ADDR_CMD) & standby_r &
                     ~pwdata[CMD_STBY_BIT];

  // One wait state; read data captured from a register
  always_comb begin
    pready_nxt = acc & ~pready_r;
    pslverr_nxt = acc & ~pready_r & refuse;
    prdata_nxt = prdata_r;
    if (acc && !pready_r && !pwrite) begin
      prdata_nxt = 32'h0;
      unique case (paddr)
        ADDR_CMD: begin
          prdata_nxt[4:0] = cmd_code_r;
          prdata_nxt[CMD_STBY_BIT] = standby_r;
        end
        ADDR_CTRL: prdata_nxt[1:0] = ctrl_r;
        ADDR_PLL: prdata_nxt[15:0] = {out_r, fb_r};
        ADDR_WAKE: prdata_nxt[16:0] = {wk_en_r, wk_reload_r};
        ADDR_TRIM: begin
          prdata_nxt[7:0] = trim_r;
          prdata_nxt[TRIM_BUSY_BIT] = trim_st_r != T_IDLE;
        end
        ADDR_STAT: begin
          prdata_nxt[STAT_CNT_LSB +: 10] = last_cnt_r;
          prdata_nxt[2:0] = {ready_r, standby_r, trim_st_r != T_IDLE};
        end
        default: prdata_nxt = 32'h0;
      endcase
    end
  end

  // Register write decode and power sequencing
  always_comb begin
    cmd_code_nxt = cmd_code_r;
    standby_nxt = standby_r;
    ctrl_nxt = ctrl_r;
    fb_nxt = fb_r;
    out_nxt = out_r;
    wk_reload_nxt = wk_reload_r;
    wk_en_nxt = wk_en_r;
    su_cnt_nxt = (su_cnt_r != '0) ? su_cnt_r - 1'b1 : su_cnt_r;
    if (wr_ok) begin
      unique case (paddr)
        ADDR_CMD: begin
          cmd_code_nxt = pwdata[4:0];
          standby_nxt = pwdata[CMD_STBY_BIT];
        end
        ADDR_CTRL: ctrl_nxt = pwdata[1:0];
        ADDR_PLL: begin
          if ((pwdata[7:0] == FB_RATIO_A || pwdata[7:0] == FB_RATIO_B ||
               pwdata[7:0] == FB_RATIO_C) &&
              pwdata[PLL_OUT_LSB +: 8] >= OUT_DIV_MIN) begin
            fb_nxt = pwdata[7:0];
            out_nxt = pwdata[PLL_OUT_LSB +: 8];
          end
        end
        ADDR_WAKE: begin
          wk_reload_nxt = pwdata[15:0];
          wk_en_nxt = pwdata[WAKE_EN_BIT];
        end
        default: ;
      endcase
    end
    if (stby_exit) begin
      su_cnt_nxt = SU_W'(STANDBY_EXIT_CYCLES);
    end
    // Fully idle command cancels the current command code
    if (abort) begin
      cmd_code_nxt = CMD_IDLE;
    end
    if (sd) begin
      cmd_code_nxt = CMD_IDLE;
      standby_nxt = 1'b0;
      ctrl_nxt = 2'h0;
      fb_nxt = FB_RATIO_A;
      out_nxt = OUT_DIV_RESET;
      wk_reload_nxt = WAKE_RELOAD_RESET;
      wk_en_nxt = 1'b0;
      su_cnt_nxt = SU_W'(STARTUP_CYCLES);
    end
    ready_nxt = ~sd & ~standby_nxt & (su_cnt_r == '0) & ~stby_exit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
      cmd_code_r <= CMD_IDLE;
      standby_r <= 1'b0;
      ctrl_r <= 2'h0;
      fb_r <= FB_RATIO_A;
      out_r <= OUT_DIV_RESET;
      wk_reload_r <= WAKE_RELOAD_RESET;
      wk_en_r <= 1'b0;
      su_cnt_r <= SU_W'(STARTUP_CYCLES);
      ready_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      cmd_code_r <= cmd_code_nxt;
      standby_r <= standby_nxt;
      ctrl_r <= ctrl_nxt;
      fb_r <= fb_nxt;
      out_r <= out_nxt;
      wk_reload_r <= wk_reload_nxt;
      wk_en_r <= wk_en_nxt;
      su_cnt_r <= su_cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ************************************************************
  // Wake-up counter and auto-trim
  // ************************************************************
  // wake-up counter on slow clock
  always_comb begin
    wk_cnt_nxt = wk_cnt_r;
    wake_evt = 1'b0;
    if (sd || !wk_en_r) begin
      wk_cnt_nxt = wk_reload_r;
    end else if (lfo_rise) begin
      if (wk_cnt_r == 16'h0) begin
        wk_cnt_nxt = wk_reload_r;
        wake_evt = 1'b1;
      end else begin
        wk_cnt_nxt = wk_cnt_r - 16'h0001;
      end
    end
  end

  // Trim sequencer
  always_comb begin
    trim_st_nxt = trim_st_r;
    trim_nxt = trim_r;
    ref_cnt_nxt = ref_cnt_r;
    last_cnt_nxt = last_cnt_r;
    unique case (trim_st_r)
      T_IDLE: begin
        if (sw_trim_wr) begin
          trim_nxt = pwdata[7:0];
        end
        if (trim_start) begin
          trim_st_nxt = T_ARM;
        end
      end
      T_ARM: begin
        if (wake_evt) begin
          ref_cnt_nxt = REF_RELOAD;
          trim_st_nxt = T_EDGE;
        end
      end
      T_EDGE: begin
        if (lfo_rise) begin
          trim_st_nxt = T_COUNT;
        end
      end
      T_COUNT: begin
        if (lfo_rise) begin
          last_cnt_nxt = ref_cnt_r;
          if (ref_cnt_r >= TRIM_LOW && ref_cnt_r <= TRIM_HIGH) begin
            trim_st_nxt = T_IDLE;
          end else begin
            trim_st_nxt = T_APPLY;
          end
        end else if (ref_rise && ref_cnt_r != 10'h0) begin
          ref_cnt_nxt = ref_cnt_r - 10'h001;
        end
      end
      T_APPLY: begin
        if (wake_evt) begin
          if (last_cnt_r < TRIM_LOW && trim_r != 8'hff) begin
            trim_nxt = trim_r + 8'h01;
          end
          if (last_cnt_r > TRIM_HIGH && trim_r != 8'h00) begin
            trim_nxt = trim_r - 8'h01;
          end
          ref_cnt_nxt = REF_RELOAD;
          trim_st_nxt = T_EDGE;
        end
      end
    endcase
    if (abort) begin
      trim_st_nxt = T_IDLE;
      trim_nxt = trim_r;
    end
    if (sd) begin
      trim_st_nxt = T_IDLE;
      trim_nxt = TRIM_RESET;
      ref_cnt_nxt = REF_RELOAD;
      last_cnt_nxt = 10'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_cnt_r <= WAKE_RELOAD_RESET;
      trim_st_r <= T_IDLE;
      trim_r <= TRIM_RESET;
      ref_cnt_r <= REF_RELOAD;
      last_cnt_r <= 10'h0;
    end else begin
      wk_cnt_r <= wk_cnt_nxt;
      trim_st_r <= trim_st_nxt;
      trim_r <= trim_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      last_cnt_r <= last_cnt_nxt;
    end
  end

  // ************************************************************
  // Clock output and radio controls
  // ************************************************************
  logic div_level;
  logic clk_pin_r, clk_pin_nxt, clk_oe_r, clk_oe_nxt;
  logic radio_r, radio_nxt;

  cpm_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(~standby_r),
    .clear(sd),
    .fb_div(fb_r),
    .out_div(out_r),
    .level(div_level)
  );

  // Pin drive; standby holds, shutdown floats
  always_comb begin
    clk_pin_nxt = standby_r ? clk_pin_r : div_level;
    clk_oe_nxt = standby_r ? clk_oe_r : ctrl_r[CTRL_CLK_EN_BIT];
    // radio off while disable bit set
    radio_nxt = standby_r ? radio_r : ~ctrl_r[CTRL_RADIO_OFF_BIT];
    // Stopped clock rests low, not just undriven
    if (sd || !ctrl_r[CTRL_CLK_EN_BIT]) begin
      clk_oe_nxt = 1'b0;
      clk_pin_nxt = 1'b0;
    end
    if (sd) begin
      clk_pin_nxt = 1'b0;
      radio_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_pin_r <= 1'b0;
      clk_oe_r <= 1'b0;
      radio_r <= 1'b0;
    end else begin
      clk_pin_r <= clk_pin_nxt;
      clk_oe_r <= clk_oe_nxt;
      radio_r <= radio_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign clock_output_pin = clk_pin_r;
  assign clock_output_pin_oe = clk_oe_r;
  assign radio_tx_on = radio_r;
  assign radio_rx_on = radio_r;
  assign slow_osc_trim = trim_r;
  assign standby_active = standby_r;
  assign device_ready = ready_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_fb_legal;
    fb_r == FB_RATIO_A || fb_r == FB_RATIO_B || fb_r == FB_RATIO_C;
  endproperty
  a_fb_legal: assert property (p_fb_legal)
    else $error("feedback ratio outside legal set");

  property p_clk_gate;
    !ctrl_r[CTRL_CLK_EN_BIT] |=> !clock_output_pin_oe && !clock_output_pin;
  endproperty
  a_clk_gate: assert property (p_clk_gate)
    else $error("clock pin driven while disabled");

  property p_reload;
    wake_evt && (trim_st_r == T_ARM || trim_st_r == T_APPLY) && !abort &&
      !sd |=> ref_cnt_r == REF_RELOAD && trim_st_r == T_EDGE;
  endproperty
  a_reload: assert property (p_reload)
    else $error("reference timer not reloaded");

  property p_inc;
    trim_st_r == T_APPLY && wake_evt && last_cnt_r < TRIM_LOW &&
      trim_r != 8'hff && !abort && !sd |=> trim_r == $past(trim_r) + 8'h01;
  endproperty
  a_inc: assert property (p_inc)
    else $error("trim not incremented");

  property p_dec;
    trim_st_r == T_APPLY && wake_evt && last_cnt_r > TRIM_HIGH &&
      trim_r != 8'h00 && !abort && !sd |=> trim_r == $past(trim_r) - 8'h01;
  endproperty
  a_dec: assert property (p_dec)
    else $error("trim not decremented");

  property p_stop;
    trim_st_r == T_COUNT && lfo_rise && ref_cnt_r >= TRIM_LOW &&
      ref_cnt_r <= TRIM_HIGH && !sd |=> trim_st_r == T_IDLE;
  endproperty
  a_stop: assert property (p_stop)
    else $error("trim did not stop in window");

  property p_abort;
    abort |=> trim_st_r == T_IDLE && $stable(trim_r);
  endproperty
  a_abort: assert property (p_abort)
    else $error("idle command did not abort trim");

  property p_hold;
    trim_st_r != T_APPLY && !sw_trim_wr && !sd |=> $stable(trim_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("trim changed outside wake-up event");

  property p_shutdown;
    sd |=> !clock_output_pin_oe && !device_ready && trim_r == TRIM_RESET;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown did not reset outputs");

  property p_retain;
    standby_r && !sd |=> $stable(ctrl_r) && $stable(fb_r) && $stable(out_r);
  endproperty
  a_retain: assert property (p_retain)
    else $error("configuration changed in standby");

  property p_wake;
    stby_exit && !sd |=> !device_ready [*8];
  endproperty
  a_wake: assert property (p_wake)
    else $error("ready too soon after standby exit");

  // Cycles since the last standby exit, saturating, for the wake cover
  logic [11:0] exit_age_r, exit_age_nxt;

  always_comb begin
    exit_age_nxt = exit_age_r;
    if (stby_exit) begin
      exit_age_nxt = 12'h000;
    end else if (exit_age_r != 12'hfff) begin
      exit_age_nxt = exit_age_r + 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_age_r <= 12'hfff;
    end else begin
      exit_age_r <= exit_age_nxt;
    end
  end

  c_trim_done: cover property (trim_st_r == T_COUNT ##1 trim_st_r == T_IDLE);
  c_stby_exit: cover property ($rose(device_ready) && exit_age_r <= 12'h7d0);
  c_clk_run: cover property (clock_output_pin_oe && $rose(clock_output_pin));

endmodule // cpm_top

// ==== tb/cpm_osc_model.sv ====
// Board oscillators: reference clock and a trim-steered slow clock.
// Assumes the block's trim output; 8 reference ticks per trim step.
module cpm_osc_model (
  // Trim from the block
  input wire logic [7:0] trim,
  // Clocks to the block
  output logic ref_clk,
  output logic slow_clk
);
  timeunit 1ns;
  timeprecision 1ns;

  // Reference, 16 ns period, kept off the pclk edges
  initial begin
    ref_clk = 1'b0;
    #1;
    forever #8 ref_clk = ~ref_clk;
  end

  // Slow clock, 848 ticks at mid trim, faster as trim rises
  initial begin
    slow_clk = 1'b0;
    #5;
    forever #((848 - 8 * (int'(trim) - 128)) * 8) slow_clk = ~slow_clk;
  end
endmodule // cpm_osc_model

// ==== tb/cpm_top_tb.sv ====
// Self-checking bench for the clock and power-mode block over APB.
// Assumes the oscillator model and a start-up count of 20.
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  miscompares++; $display("MISMATCH t=%0t got %h", $time, got); end end
module cpm_top_tb import cpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Signals
  // ************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
  logic [7:0] paddr, slow_osc_trim;
  logic [31:0] pwdata, prdata, rd_d;
  logic shutdown_pin, slow_osc_in, xtal_ref_in, standby_active;
  logic clock_output_pin, clock_output_pin_oe, radio_tx_on, radio_rx_on;
  logic device_ready;
  int miscompares = 0, cmp_count = 0, n, e;
  logic [7:0] fb [7] = '{8'h17, 8'h1b, 8'h17, 8'h1c, 8'h17, 8'h1c, 8'h17};
  logic [7:0] ov [7] = '{8'h4e, 8'h3d, 8'h27, 8'h26, 8'h1a, 8'h13, 8'h10};

  cpm_top #(.STARTUP_CYCLES(20)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .shutdown_pin,
    .slow_osc_in, .xtal_ref_in, .clock_output_pin, .clock_output_pin_oe,
    .radio_tx_on, .radio_rx_on, .slow_osc_trim, .standby_active,
    .device_ready);
  cpm_osc_model osc (.trim(slow_osc_trim), .ref_clk(xtal_ref_in),
    .slow_clk(slow_osc_in));

  // Bus clock, 8 ns
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(k < 20, 1'b1)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // Edges seen on the clock pin over c cycles
  task automatic toggles(input int c, output int t);
    logic p;
    t = 0;
    p = clock_output_pin;
    repeat (c) begin
      @(posedge pclk);
      if (clock_output_pin !== p) t++;
      p = clock_output_pin;
    end
  endtask
  task automatic wait_ready(output int c);
    c = 0;
    while (device_ready !== 1'b1 && c < 4000) begin
      @(posedge pclk);
      c++;
    end
  endtask
  task automatic wait_trim(input logic [7:0] v);
    int k;
    k = 0;
    while (slow_osc_trim !== v && k < 40000) begin
      @(posedge pclk);
      k++;
    end
  endtask
  // Poll the status word until trimming is no longer busy
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      cyc(64);
      rd(ADDR_STAT);
      k++;
    end while (rd_d[0] !== 1'b0 && k < 800);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    {presetn, psel, penable, pwrite, shutdown_pin} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    `CHK(slow_osc_trim, TRIM_RESET)
    presetn <= 1'b1;
    wait_ready(n);
    `CHK(n > 18 && n < 24, 1'b1)
    rd(ADDR_PLL);
    `CHK(rd_d, {16'h0, OUT_DIV_RESET, FB_RATIO_A})
    rd(8'h18);
    `CHK({rd_e, rd_d}, 33'h100000000)
    `CHK({radio_tx_on, radio_rx_on}, 2'b11)
    wr(ADDR_CTRL, 32'h1);
    cyc(2);
    `CHK({radio_tx_on, radio_rx_on}, 2'b00)
    wr(ADDR_CTRL, 32'h2);
    cyc(2);
    `CHK({radio_tx_on, radio_rx_on, clock_output_pin_oe}, 3'h7)
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_PLL, {16'h0, ov[i], fb[i]});
      rd(ADDR_PLL);
      `CHK(rd_d[15:0], {ov[i], fb[i]})
      toggles(1000, n);
      e = (2712 * fb[i] * 1000) / (12500 * ov[i]);
      `CHK(n + 1 >= e && n <= e + 1, 1'b1)
    end
    wr(ADDR_PLL, 32'h1019);
    wr(ADDR_PLL, 32'h0f17);
    rd(ADDR_PLL);
    `CHK(rd_d, 32'h1017)
    wr(ADDR_CTRL, 32'h0);
    cyc(2);
    toggles(200, n);
    `CHK(n == 0 && clock_output_pin_oe === 1'b0, 1'b1)
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_CMD, 32'h80);
    cyc(2);
    `CHK({standby_active, device_ready}, 2'b10)
    toggles(200, n);
    `CHK(n == 0 && clock_output_pin_oe === 1'b1, 1'b1)
    wr(ADDR_CTRL, 32'h0);
    `CHK(rd_e, 1'b1)
    rd(ADDR_CTRL);
    `CHK(rd_d, 32'h2)
    wr(ADDR_CMD, 32'h0);
    wait_ready(n);
    `CHK(n > 1869 && n < 1881, 1'b1)
    // reload above 0x05, no presence check
    wr(ADDR_WAKE, 32'h6);
    wr(ADDR_WAKE, 32'h10006);
    wr(ADDR_TRIM, 32'h7f);
    wr(ADDR_TRIM, 32'h17f);
    wait_trim(8'h80);
    `CHK(slow_osc_trim, 8'h80)
    wait_idle();
    `CHK(rd_d[25:16] > 173 && rd_d[25:16] < 177, 1'b1)
    `CHK(slow_osc_trim, 8'h80)
    wr(ADDR_TRIM, 32'h82);
    wr(ADDR_TRIM, 32'h182);
    wait_trim(8'h81);
    `CHK(slow_osc_trim, 8'h81)
    wr(ADDR_CMD, 32'h0);
    rd(ADDR_TRIM);
    `CHK(rd_d[9:0], 10'h081)
    cyc(16000);
    `CHK(slow_osc_trim, 8'h81)
    shutdown_pin <= 1'b1;
    cyc(4);
    `CHK({clock_output_pin_oe, radio_tx_on, device_ready}, 3'h0)
    rd(ADDR_CTRL);
    `CHK(rd_e, 1'b1)
    shutdown_pin <= 1'b0;
    wait_ready(n);
    `CHK(n > 18 && n < 28, 1'b1)
    rd(ADDR_CTRL);
    `CHK(rd_d, 32'h0)
    `CHK(slow_osc_trim, TRIM_RESET)
    print_verdict();
  end

  // Watchdog for a hung run
  initial begin
    #760000;
    miscompares++;
    print_verdict();
  end
endmodule // cpm_top_tb
